/* File: rtl/cfg_store.sv */
`default_nettype none
// retained user-constant store: survives the power-on reset on purpose,
// so it carries no reset at all; read data come out of a register
module cfg_store
  import servo_cfg_pkg::*;
#(
  parameter int WORDS = NV_WORDS
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [NV_IW-1:0] widx_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic mark_i,
  input wire logic [NV_IW-1:0] ridx_i,
  output logic [DW-1:0] rdata_o
);

  // whole state of the store
  typedef struct packed {
    logic [WORDS-1:0][DW-1:0] mem;   // retained words
    logic [DW-1:0] rdata;            // registered read word
  } store_s;

  store_s st_r;
  store_s st_nxt;

  // write, mark and read for the coming edge
  always_comb begin
    st_nxt = st_r;
    if (we_i) begin
      st_nxt.mem[widx_i] = wdata_i;
    end
    // mark says at least one stored word was written
    if (mark_i) begin
      st_nxt.mem[NV_IX_MARK] = NV_MARK;
    end
    st_nxt.rdata = st_r.mem[ridx_i];
  end

  // no reset: contents must outlive a power cycle
  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign rdata_o = st_r.rdata;

endmodule
`default_nettype wire

/* File: rtl/servo_cfg_pkg.sv */
`default_nettype none
package servo_cfg_pkg;

  // register port geometry
  localparam int AW = 4;
  localparam int DW = 16;

  // register word addresses
  localparam logic [AW-1:0] A_PFS = 4'h0;     // stored primary switch
  localparam logic [AW-1:0] A_SFS = 4'h1;     // stored secondary switch
  localparam logic [AW-1:0] A_PPR = 4'h2;     // stored pulses per rev
  localparam logic [AW-1:0] A_MOFF = 4'h3;    // manual reference offset
  localparam logic [AW-1:0] A_CTRL = 4'h4;    // offset control
  localparam logic [AW-1:0] A_STAT = 4'h5;    // running status
  localparam logic [AW-1:0] A_RPFS = 4'h6;    // running primary switch
  localparam logic [AW-1:0] A_RSFS = 4'h7;    // running secondary switch
  localparam logic [AW-1:0] A_RPPR = 4'h8;    // running pulses per rev
  localparam logic [AW-1:0] A_AOFF = 4'h9;    // captured automatic offset

  // switch field positions
  localparam int PFS_STOP_BIT = 6;   // 0 short-circuit brake, 1 coast
  localparam int PFS_HOLD_BIT = 7;   // 1 keep brake after stop
  localparam int SFS_MOTOR_BIT = 8;  // 0 standard, 1 flat motor
  localparam int SFS_ENC_BIT = 9;    // 0 incremental, 1 absolute

  // control register fields
  localparam int CTRL_AUTO_SEL = 0;  // 1 applies the automatic offset
  localparam int CTRL_NULL_GO = 1;   // write 1: capture offset now
  localparam int CTRL_RESTORE = 2;   // write 1: load pulses preset

  // reset and preset values
  localparam logic [DW-1:0] PFS_RST = 16'h0080;
  localparam logic [DW-1:0] SFS_RST = 16'h0000;
  localparam logic [DW-1:0] PPR_INC = 16'h0800;   // 2048 pulses
  localparam logic [DW-1:0] PPR_ABS = 16'h0400;   // 1024 pulses
  // validity mark of the retained store; value is arbitrary
  localparam logic [DW-1:0] NV_MARK = 16'h5a3c;

  // retained store layout
  localparam int NV_WORDS = 4;
  localparam int NV_IW = 2;
  localparam logic [NV_IW-1:0] NV_IX_PFS = 2'h0;
  localparam logic [NV_IW-1:0] NV_IX_SFS = 2'h1;
  localparam logic [NV_IW-1:0] NV_IX_PPR = 2'h2;
  localparam logic [NV_IW-1:0] NV_IX_MARK = 2'h3;
  localparam logic [2:0] BOOT_LAST = 3'h4;   // step that checks the mark

  // one set of configuration words
  typedef struct packed {
    logic [DW-1:0] pfs;
    logic [DW-1:0] sfs;
    logic [DW-1:0] ppr;
  } cfg_s;

  // servo-off sources coming from pins
  typedef struct packed {
    logic servo_on;
    logic power_ok;
  } pins_s;

  // stop sequencer states
  typedef enum logic [2:0] {
    SS_OFF,
    SS_RUN,
    SS_BRAKE,
    SS_COAST,
    SS_HOLD
  } stop_e;

endpackage
`default_nettype wire

/* File: rtl/servo_cfg_stop.sv */
// Function
// - secondary bit 9 picks encoder, default incremental
// - incremental encoder uses 2048 pulses per rev
// - absolute encoder uses 1024 pulses per rev
// - switch changes apply only after power cycle
// - pulses constant change applies after power cycle
// - secondary bit 8 picks standard or flat motor
// - servo-off on enable low, alarm, power loss
// - primary bit 6 picks short brake or coast
// - hold bit 0 releases brake after stop
// - hold bit 1 keeps brake after stop
// - hold bit defaults to one
// - hold bit ignored in coast mode
// - offset nulled automatically or set manually
// - short brake shorts windings for sudden stop
//
// Strobed register access and the placing of the registers were left to the implementer.
`default_nettype none
module servo_cfg_stop
  import servo_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  input wire logic servo_on_i,
  input wire logic main_power_i,
  input wire logic alarm_i,
  input wire logic motor_stopped_i,
  input wire logic [DW-1:0] ref_i,
  output logic [DW-1:0] corr_ref_o,
  output logic motor_power_o,
  output logic short_brake_o,
  output logic servo_off_o,
  output logic enc_abs_o,
  output logic motor_flat_o,
  output logic [DW-1:0] ppr_o,
  output logic cfg_ready_o
);

  // whole state of the block
  typedef struct packed {
    pins_s s1;               // first synchroniser stage
    pins_s s2;               // second synchroniser stage
    logic [2:0] bidx;        // power-up load step
    logic boot_done;         // running set has been latched
    cfg_s tmp;               // words gathered during the load
    cfg_s shadow;            // stored set as software sees it
    cfg_s run;               // set latched at power-up
    logic [DW-1:0] man_off;  // manual offset
    logic [DW-1:0] auto_off; // captured automatic offset
    logic auto_sel;          // applies the automatic offset
    logic [DW-1:0] rdata;    // read word, valid one cycle
    logic [DW-1:0] corr;     // corrected speed reference
    stop_e stop;             // stop sequencer
    logic power;             // motor power stage enabled
    logic brake;             // windings shorted
    logic off;               // servo-off status
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // store access lines; all but nv_rdata driven from the same comb process
  logic nv_we;
  logic [NV_IW-1:0] nv_widx;
  logic [DW-1:0] nv_wdata;
  logic nv_mark;
  logic [DW-1:0] nv_rdata;
  logic off_req;
  logic [DW-1:0] preset;

  cfg_store #(
    .WORDS(NV_WORDS)
  ) u_store (
    .clk_i(clk_i),
    .we_i(nv_we),
    .widx_i(nv_widx),
    .wdata_i(nv_wdata),
    .mark_i(nv_mark),
    .ridx_i(st_r.bidx[NV_IW-1:0]),
    .rdata_o(nv_rdata)
  );

  // next state: sync, power-up load, bus, offset, stop sequencer
  always_comb begin
    st_nxt = st_r;
    nv_we = 1'b0;
    nv_widx = NV_IX_PFS;
    nv_wdata = wdata_i;
    nv_mark = 1'b0;
    // preset follows the stored encoder choice
    preset = st_r.shadow.sfs[SFS_ENC_BIT] ? PPR_ABS : PPR_INC;

    // enable and power pins pass two flops before anything reads them; alarm_i is read directly
    st_nxt.s1.servo_on = servo_on_i;
    st_nxt.s1.power_ok = main_power_i;
    st_nxt.s2 = st_r.s1;

    // power-up load: store words arrive one cycle after their index
    if (!st_r.boot_done) begin
      st_nxt.bidx = st_r.bidx + 3'h1;
      case (st_r.bidx)
        3'h1: st_nxt.tmp.pfs = nv_rdata;
        3'h2: st_nxt.tmp.sfs = nv_rdata;
        3'h3: st_nxt.tmp.ppr = nv_rdata;
        BOOT_LAST: begin
          st_nxt.boot_done = 1'b1;
          // an unwritten store falls back to the factory set
          if (nv_rdata == NV_MARK) begin
            st_nxt.run = st_r.tmp;
            st_nxt.shadow = st_r.tmp;
          end
        end
        default: ;
      endcase
    end

    // read data stand only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        A_PFS: st_nxt.rdata = st_r.shadow.pfs;
        A_SFS: st_nxt.rdata = st_r.shadow.sfs;
        A_PPR: st_nxt.rdata = st_r.shadow.ppr;
        A_MOFF: st_nxt.rdata = st_r.man_off;
        A_CTRL: st_nxt.rdata = {15'h0000, st_r.auto_sel};
        A_STAT: st_nxt.rdata = {4'h0, st_r.boot_done, st_r.off,
                                st_r.brake, st_r.power, 3'(st_r.stop),
                                1'b0, st_r.run.sfs[SFS_ENC_BIT],
                                st_r.run.sfs[SFS_MOTOR_BIT], 2'h0};
        A_RPFS: st_nxt.rdata = st_r.run.pfs;
        A_RSFS: st_nxt.rdata = st_r.run.sfs;
        A_RPPR: st_nxt.rdata = st_r.run.ppr;
        A_AOFF: st_nxt.rdata = st_r.auto_off;
        default: st_nxt.rdata = '0;
      endcase
    end

    // writes to the stored words land in the store and the shadow, never the running set
    if (wr_i) begin
      unique case (addr_i)
        A_PFS: begin
          st_nxt.shadow.pfs = wdata_i;
          nv_we = 1'b1;
          nv_widx = NV_IX_PFS;
          nv_mark = 1'b1;
        end
        A_SFS: begin
          st_nxt.shadow.sfs = wdata_i;
          nv_we = 1'b1;
          nv_widx = NV_IX_SFS;
          nv_mark = 1'b1;
        end
        A_PPR: begin
          st_nxt.shadow.ppr = wdata_i;
          nv_we = 1'b1;
          nv_widx = NV_IX_PPR;
          nv_mark = 1'b1;
        end
        A_MOFF: st_nxt.man_off = wdata_i;
        A_CTRL: begin
          st_nxt.auto_sel = wdata_i[CTRL_AUTO_SEL];
          // capture the present reference as its own offset
          if (wdata_i[CTRL_NULL_GO]) begin
            st_nxt.auto_off = ref_i;
          end
          if (wdata_i[CTRL_RESTORE]) begin
            st_nxt.shadow.ppr = preset;
            nv_we = 1'b1;
            nv_widx = NV_IX_PPR;
            nv_wdata = preset;
            nv_mark = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // automatic nulling brings a steady reference to zero
    st_nxt.corr = ref_i - (st_r.auto_sel ? st_r.auto_off
                                         : st_r.man_off);

    // any cause requests the same servo-off sequence
    off_req = !st_r.s2.servo_on || alarm_i || !st_r.s2.power_ok;
    unique case (st_r.stop)
      SS_OFF: begin
        if (st_r.boot_done && !off_req) begin
          st_nxt.stop = SS_RUN;
        end
      end
      SS_RUN: begin
        if (off_req) begin
          st_nxt.stop = st_r.run.pfs[PFS_STOP_BIT] ? SS_COAST
                                                   : SS_BRAKE;
        end
      end
      SS_BRAKE: begin
        // hold bit counts only after a short-circuit stop
        if (motor_stopped_i) begin
          st_nxt.stop = st_r.run.pfs[PFS_HOLD_BIT] ? SS_HOLD
                                                   : SS_OFF;
        end
      end
      SS_COAST: begin
        if (motor_stopped_i) begin
          st_nxt.stop = SS_OFF;
        end
      end
      SS_HOLD: begin
        if (!off_req) begin
          st_nxt.stop = SS_RUN;
        end
      end
    endcase
    // outputs follow the state on the same edge
    st_nxt.power = (st_nxt.stop == SS_RUN);
    st_nxt.brake = (st_nxt.stop == SS_BRAKE) ||
                   (st_nxt.stop == SS_HOLD);
    st_nxt.off = (st_nxt.stop != SS_RUN);
  end

  // single register of the block; factory set at reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.tmp.pfs <= PFS_RST;
      st_r.tmp.sfs <= SFS_RST;
      st_r.tmp.ppr <= PPR_INC;
      st_r.shadow.pfs <= PFS_RST;
      st_r.shadow.sfs <= SFS_RST;
      st_r.shadow.ppr <= PPR_INC;
      st_r.run.pfs <= PFS_RST;
      st_r.run.sfs <= SFS_RST;
      st_r.run.ppr <= PPR_INC;
      st_r.stop <= SS_OFF;
      st_r.off <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output is a flop of the state
  assign rdata_o = st_r.rdata;
  assign corr_ref_o = st_r.corr;
  assign motor_power_o = st_r.power;
  assign short_brake_o = st_r.brake;
  assign servo_off_o = st_r.off;
  assign enc_abs_o = st_r.run.sfs[SFS_ENC_BIT];
  assign motor_flat_o = st_r.run.sfs[SFS_MOTOR_BIT];
  assign ppr_o = st_r.run.ppr;
  assign cfg_ready_o = st_r.boot_done;

  // checks on the block's own state and outputs
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_run_set_frozen: assert property (
    st_r.boot_done && $past(st_r.boot_done) |-> $stable(st_r.run))
    else $error("running set changed after power-up");
  a_ppr_frozen: assert property (
    wr_i && addr_i == A_PPR && st_r.boot_done |=> $stable(ppr_o) [*4])
    else $error("pulses constant applied early");
  a_preset_inc: assert property (
    wr_i && addr_i == A_CTRL && wdata_i[CTRL_RESTORE] &&
    !st_r.shadow.sfs[SFS_ENC_BIT] |=> st_r.shadow.ppr == 16'h0800)
    else $error("incremental preset not 2048");
  a_preset_abs: assert property (
    wr_i && addr_i == A_CTRL && wdata_i[CTRL_RESTORE] &&
    st_r.shadow.sfs[SFS_ENC_BIT] |=> st_r.shadow.ppr == 16'h0400)
    else $error("absolute preset not 1024");
  a_off_entry: assert property (
    st_r.stop == SS_RUN && (alarm_i || !st_r.s2.power_ok ||
    !st_r.s2.servo_on) |=> servo_off_o && !motor_power_o)
    else $error("servo-off not entered");
  a_brake_stop: assert property (
    st_r.stop == SS_RUN && off_req && !st_r.run.pfs[PFS_STOP_BIT]
    |=> short_brake_o) else $error("short brake not applied");
  a_coast_stop: assert property (
    st_r.stop == SS_RUN && off_req && st_r.run.pfs[PFS_STOP_BIT]
    |=> !short_brake_o [*2]) else $error("brake applied in coast");
  a_brake_release: assert property (
    st_r.stop == SS_BRAKE && motor_stopped_i &&
    !st_r.run.pfs[PFS_HOLD_BIT] |=> !short_brake_o && servo_off_o)
    else $error("brake not released after stop");
  a_brake_hold: assert property (
    st_r.stop == SS_BRAKE && motor_stopped_i &&
    st_r.run.pfs[PFS_HOLD_BIT] && off_req ##1 off_req |=> short_brake_o)
    else $error("brake released despite hold");
  a_auto_null: assert property (
    wr_i && addr_i == A_CTRL && wdata_i[CTRL_NULL_GO] &&
    wdata_i[CTRL_AUTO_SEL] ##1 $stable(ref_i) |=> corr_ref_o == 16'h0000)
    else $error("automatic offset does not null");

  c_brake_hold: cover property (
    st_r.stop == SS_BRAKE ##[1:50] st_r.stop == SS_HOLD);
  c_coast_off: cover property (
    st_r.stop == SS_COAST ##[1:50] st_r.stop == SS_OFF);
  c_rearm: cover property (
    st_r.stop == SS_HOLD ##1 st_r.stop == SS_RUN);

endmodule
`default_nettype wire

/* File: tb/motor_model.sv */
`default_nettype none
// behavioural motor: gains speed while the power stage is on, stops
// within a few cycles when its windings are shorted, and coasts down
// slowly on friction alone otherwise
module motor_model #(
  parameter int VMAX = 40,    // top speed, arbitrary steps
  parameter int BRK_STEP = 8  // speed lost per cycle with windings shorted
) (
  input wire logic clk_i,
  input wire logic motor_power_i,
  input wire logic short_brake_i,
  output logic motor_stopped_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int speed = 0; // present speed, starts at standstill

  // speed follows the power stage and the winding short
  always @(posedge clk_i) begin
    if (motor_power_i) begin
      speed <= (speed < VMAX) ? speed + 4 : VMAX;
    end else if (short_brake_i) begin
      // shorted windings give a sudden stop
      speed <= (speed > BRK_STEP) ? speed - BRK_STEP : 0;
    end else if (speed > 0) begin
      // no power, no short: friction only, so the stop is slow
      speed <= speed - 1;
    end
  end

  // standstill flag seen by the drive on the same clock
  assign motor_stopped_o = (speed == 0);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top
  import servo_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [AW-1:0] addr_i = '0;
  logic [DW-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic servo_on_i = 1'b0;
  logic main_power_i = 1'b0;
  logic alarm_i = 1'b0;
  logic motor_stopped_i;
  logic [DW-1:0] ref_i = '0;
  logic [DW-1:0] rdata_o;
  logic [DW-1:0] corr_ref_o;
  logic motor_power_o;
  logic short_brake_o;
  logic servo_off_o;
  logic enc_abs_o;
  logic motor_flat_o;
  logic [DW-1:0] ppr_o;
  logic cfg_ready_o;
  int err_count = 0;  // mismatches seen
  int n_compared = 0; // comparisons made

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  servo_cfg_stop DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .servo_on_i(servo_on_i), .main_power_i(main_power_i),
    .alarm_i(alarm_i), .motor_stopped_i(motor_stopped_i),
    .ref_i(ref_i), .corr_ref_o(corr_ref_o),
    .motor_power_o(motor_power_o), .short_brake_o(short_brake_o),
    .servo_off_o(servo_off_o), .enc_abs_o(enc_abs_o),
    .motor_flat_o(motor_flat_o), .ppr_o(ppr_o),
    .cfg_ready_o(cfg_ready_o)
  );

  motor_model motor (
    .clk_i(clk_i), .motor_power_i(motor_power_o),
    .short_brake_i(short_brake_o), .motor_stopped_o(motor_stopped_i)
  );

  // verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // single comparison point; case inequality so unknowns never match
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // one-cycle read strobe; data only stand in the following cycle
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // selects a flag to wait on
  function automatic logic pick(input int w);
    case (w)
      0: return cfg_ready_o;
      1: return motor_power_o;
      2: return servo_off_o;
      default: return motor_stopped_i;
    endcase
  endfunction

  // bounded wait; running out of cycles ends the run as a failure
  task automatic wait_for(input int w);
    int n;
    n = 0;
    while (pick(w) !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 400) begin
        err_count++;
        $display("[FAIL] %0t wait %0d timed out", $time, w);
        end_of_test();
      end
    end
  endtask

  // power cycle: pins drop, reset held 4 cycles, wait for the load
  task automatic pcycle();
    @(posedge clk_i);
    servo_on_i <= 1'b0;
    main_power_i <= 1'b0;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    // reset values while the reset is still held
    chk(cfg_ready_o, 1'b0);
    chk(servo_off_o, 1'b1);
    rst_n_i <= 1'b1;
    wait_for(0);
    // keep clear of the load before the first bus request
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // expected stored pulse count after a restore request
  function automatic logic [DW-1:0] preset(input logic [DW-1:0] sfs);
    return sfs[9] ? 16'h0400 : 16'h0800;
  endfunction

  initial begin
    logic [DW-1:0] p;
    logic [DW-1:0] m;
    logic [DW-1:0] r;
    logic [DW-1:0] pfs;
    void'($urandom(26732));
    pcycle();
    // factory set, store empty at first power-up
    chk(ppr_o, 16'h0800);
    chk(enc_abs_o, 1'b0);
    chk(motor_flat_o, 1'b0);
    rdc(A_RPFS, 16'h0080);
    rdc(A_RSFS, 16'h0000);
    rdc(4'hf, 16'h0000);
    // status: loaded, servo off, idle, factory encoder and motor
    rdc(A_STAT, 16'h0c00);
    // stored changes must not reach the running set before power cycle
    p = 16'($urandom);
    // every stored word written, so no stale word reaches the run set
    wr(A_PFS, PFS_RST);
    wr(A_SFS, 16'h0300);
    wr(A_PPR, p);
    rdc(A_SFS, 16'h0300);
    chk(ppr_o, 16'h0800);
    chk(enc_abs_o, 1'b0);
    chk(motor_flat_o, 1'b0);
    rdc(A_RPPR, 16'h0800);
    pcycle();
    chk(enc_abs_o, 1'b1);
    chk(motor_flat_o, 1'b1);
    chk(ppr_o, p);
    // presets for both encoder types, each applied after power cycle
    wr(A_CTRL, 16'h0004);
    rdc(A_PPR, preset(16'h0300));
    pcycle();
    chk(ppr_o, 16'h0400);
    wr(A_SFS, 16'h0000);
    wr(A_CTRL, 16'h0004);
    rdc(A_PPR, preset(16'h0000));
    pcycle();
    chk(ppr_o, 16'h0800);
    chk(enc_abs_o, 1'b0);
    // manual offset, as a host closing its own loop must use
    for (int i = 0; i < 6; i++) begin
      m = 16'($urandom);
      r = (i == 0) ? 16'h8000 : 16'($urandom);
      wr(A_MOFF, m);
      wr(A_CTRL, 16'h0000);
      @(posedge clk_i);
      ref_i <= r;
      repeat (2) @(posedge clk_i);
      #1;
      chk(corr_ref_o, r - m);
    end
    // automatic nulling drives the corrected reference to zero
    r = 16'($urandom);
    @(posedge clk_i);
    ref_i <= r;
    wr(A_CTRL, 16'h0002);
    wr(A_CTRL, 16'h0001);
    repeat (2) @(posedge clk_i);
    #1;
    chk(corr_ref_o, 16'h0000);
    rdc(A_AOFF, r);
    // capture and apply in one write
    r = 16'($urandom);
    @(posedge clk_i);
    ref_i <= r;
    wr(A_CTRL, 16'h0003);
    repeat (2) @(posedge clk_i);
    #1;
    chk(corr_ref_o, 16'h0000);
    rdc(A_AOFF, r);
    // every stop setting against every servo-off cause
    for (int s = 0; s < 4; s++) begin
      pfs = PFS_RST;
      pfs[6] = s[0];
      pfs[7] = s[1];
      wr(A_PFS, pfs);
      pcycle();
      rdc(A_RPFS, pfs);
      for (int c = 0; c < 3; c++) begin
        @(posedge clk_i);
        servo_on_i <= 1'b1;
        main_power_i <= 1'b1;
        alarm_i <= 1'b0;
        wait_for(1);
        // let the motor reach speed before cutting it off
        repeat (60) @(posedge clk_i);
        case (c)
          0: servo_on_i <= 1'b0;
          1: alarm_i <= 1'b1;
          default: main_power_i <= 1'b0;
        endcase
        wait_for(2);
        chk(short_brake_o, !pfs[6]);
        chk(motor_power_o, 1'b0);
        wait_for(3);
        repeat (4) @(posedge clk_i);
        #1;
        chk(short_brake_o, !pfs[6] && pfs[7]);
        chk(servo_off_o, 1'b1);
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
